// ===== verilog/brs_pkg.sv
// Purpose: shared constants and types for the bcd real-time clock with alarm and square wave
// Assumes: 100 mhz system clock, crystal level sampled as a plain synchronous input
// Notes:   offsets are the byte addresses seen over the two-wire target port
package brs_pkg;

   // register byte addresses
   localparam logic [7:0] ADDR_CTRL_A  = 8'h00;
   localparam logic [7:0] ADDR_CTRL_B  = 8'h01;
   localparam logic [7:0] ADDR_SEC     = 8'h02;
   localparam logic [7:0] ADDR_MIN     = 8'h03;
   localparam logic [7:0] ADDR_HOUR    = 8'h04;
   localparam logic [7:0] ADDR_DATE    = 8'h05;
   localparam logic [7:0] ADDR_WDAY    = 8'h06;
   localparam logic [7:0] ADDR_MONTH   = 8'h07;
   localparam logic [7:0] ADDR_YEAR    = 8'h08;
   localparam logic [7:0] ADDR_AL_MIN  = 8'h09;
   localparam logic [7:0] ADDR_AL_HOUR = 8'h0a;
   localparam logic [7:0] ADDR_AL_DATE = 8'h0b;
   localparam logic [7:0] ADDR_AL_WDAY = 8'h0c;
   localparam logic [7:0] ADDR_SQW     = 8'h0d;

   // target address on the two-wire bus
   localparam logic [6:0] TARGET_ADDR  = 7'h51;

   // field positions
   localparam int OSF_BIT  = 7;
   localparam int AF_BIT   = 3;
   localparam int AIE_BIT  = 1;
   localparam int AE_BIT   = 7;
   localparam int SQUARE_OUT_ENABLE_BIT = 7;

   // values after reset
   localparam logic       OSF_RST   = 1'b1;
   localparam logic       AF_RST    = 1'b0;
   localparam logic       AIE_RST   = 1'b0;
   localparam logic       SQUARE_OUT_ENABLE_RST  = 1'b1;
   localparam logic [1:0] RATE_RST  = 2'h0;
   localparam logic [3:0] AE_RST    = 4'hf;
   localparam logic [5:0] DATE_RST  = 6'h01;
   localparam logic [4:0] MONTH_RST = 5'h01;

   // bcd limits
   localparam logic [6:0] BCD_59     = 7'h59;
   localparam logic [5:0] HOUR_LAST  = 6'h23;
   localparam logic [2:0] WDAY_LAST  = 3'h6;
   localparam logic [4:0] MONTH_LAST = 5'h12;
   localparam logic [4:0] MONTH_FEB  = 5'h02;
   localparam logic [7:0] YEAR_LAST  = 8'h99;

   // crystal divider: 32768 crystal edges make one second
   localparam int          PRESC_W    = 15;
   localparam logic [14:0] PRESC_LAST = 15'h7fff;
   localparam int          TAP_1K     = 4;
   localparam int          TAP_32     = 9;
   localparam int          TAP_1      = 14;

   // oscillator stop detection window
   localparam int CLK_PERIOD_NS  = 10;
   localparam int OSC_TIMEOUT_NS = 100000;
   localparam int OSC_TIMEOUT_CYC = (OSC_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OSC_CNT_W      = 16;

   typedef enum logic [2:0] {
      ST_IDLE     = 3'b000,
      ST_ADDR     = 3'b001,
      ST_ADDR_ACK = 3'b011,
      ST_RX       = 3'b010,
      ST_RX_ACK   = 3'b110,
      ST_TX       = 3'b111,
      ST_TX_ACK   = 3'b101
   } brs_i2c_state_t;

endpackage : brs_pkg

// ===== verilog/brs_rtc.sv
// Purpose: bcd clock/calendar with alarm, oscillator-fail flag and square wave, two-wire target
// Assumes: scl, sda and the crystal level are sampled directly on clk
// Notes:   open-drain pins are level/oe pairs, oe high pulls the pin low
//
// Operation
// R01: seconds advance once per 32768 crystal edges.
// R02: host reads and writes year, month, date, weekday, hour, minute, second.
// R03: time counters kept packed bcd at 02..08, unused bits not stored.
// R04: hours count 00..23 only; wrap past 23 advances the date.
// R05: date wraps to 1 after the month length and carries into month.
// R06: every year multiple of four, 00 included, gives february 29 days.
// R07: month runs 1..12 and carries into year on wrap.
// R08: year runs 00..99 and wraps to 00.
// R09: weekday counts 0..6 modulo seven with each date step.
// R10: host writes only legal bcd values and sequential weekday codes.
// R11: oscillator-fail flag in seconds bit 7 sets on stop, reads 1 after reset.
// R12: host rewrites time when it sees the oscillator-fail flag set.
// R13: alarm fields at 09..0c compare only when their bit 7 is 0.
// R14: one alarm channel signals on the interrupt pin when enabled fields match.
// R15: alarm irq enable, bit 1 of 01, gates the pin; resets to 0.
// R16: alarm flag bit 3 of 01 reads pending; write 0 clears, 1 keeps.
// R17: interrupt pin is open drain, active low, pulls low while asserted.
// R18: square-out enable bit 7 of 0d drives the pin, else floats; resets 1.
// R19: rate select 00 32.768k, 01 1.024k, 10 32 hz, 11 1 hz; resets 00.
// R20: unused bit positions, all of register 00, have no storage.
// R21: all register access passes the two-wire target port, at most 400 khz.
// R22: alarm flag sets only on a fresh match of the enabled fields.
// R23: writing 0 clears oscillator-fail; writing seconds restarts the divider.
// R24: unused bits read 0 and ignore writes.
`timescale 1ns/1ns
`default_nettype none

module brs_rtc
   import brs_pkg::*;
#(
   parameter int OSC_TIMEOUT_CYCLES = OSC_TIMEOUT_CYC
) (
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic scl,
   input  wire logic sda_pin,
   output logic      sda_level,
   output logic      sda_oe,
   input  wire logic xtal_in,
   output logic      xtal_out,
   output logic      irq_n_level,
   output logic      irq_n_oe,
   output logic      square_out,
   output logic      square_out_oe
);

   localparam logic [OSC_CNT_W-1:0] OSC_LIMIT = OSC_CNT_W'(OSC_TIMEOUT_CYCLES);

   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      if (v[3:0] == 4'h9) begin
         bcd_inc = {v[7:4] + 4'h1, 4'h0};
      end else begin
         bcd_inc = {v[7:4], v[3:0] + 4'h1};
      end
   endfunction : bcd_inc

   // leap test on two bcd digits: (2*tens + units) mod 4
   function automatic logic [5:0] month_len(input logic [4:0] m, input logic [7:0] y);
      logic [1:0] ysum;
      ysum = y[1:0] + {y[4], 1'b0};
      case (m)
         MONTH_FEB: month_len = (ysum == 2'b00) ? 6'h29 : 6'h28;
         5'h04, 5'h06, 5'h09, 5'h11: month_len = 6'h30;
         default: month_len = 6'h31;
      endcase
   endfunction : month_len

   // time and calendar state
   logic [6:0]           sec_q, min_q;
   logic [5:0]           hour_q, date_q;
   logic [2:0]           wday_q;
   logic [4:0]           month_q;
   logic [7:0]           year_q;
   // alarm, control and oscillator state
   logic [3:0]           ae_q;
   logic [6:0]           al_min_q;
   logic [5:0]           al_hour_q, al_date_q;
   logic [2:0]           al_wday_q;
   logic                 af_q, aie_q, osf_q, square_out_enable_q, match_q, sq_wave_q;
   logic [1:0]           rate_q;
   logic                 xtal_q, xtal_out_q;
   logic [PRESC_W-1:0]   presc_q;
   logic [OSC_CNT_W-1:0] idle_q;
   // two-wire target state
   brs_i2c_state_t       state_q;
   logic                 scl_q, sda_q, rw_q, first_q, nack_q, sda_oe_q;
   logic [3:0]           cnt_q;
   logic [7:0]           shreg_q, tx_q, ptr_q;

   logic       xtal_rise, tick, osc_dead, wr_en, wr_sec;
   logic [7:0] wr_data, rd_data, ptr_next;
   logic [7:0] sec_nx, min_nx, hour_nx, date_nx, month_nx, year_nx;
   logic [5:0] mlen;
   logic       sec_wrap, min_wrap, hour_wrap, day_roll, date_wrap, month_wrap;
   logic       alarm_match, alarm_hit;
   logic       scl_rise, scl_fall, bus_start, bus_stop;

   // crystal divider and oscillator watch
   assign xtal_rise = xtal_in & ~xtal_q;
   assign wr_sec    = wr_en && (ptr_q == ADDR_SEC);
   assign tick      = xtal_rise && (presc_q == PRESC_LAST) && !wr_sec; // R01
   assign osc_dead  = (idle_q == OSC_LIMIT);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         xtal_q     <= 1'b0;
         xtal_out_q <= 1'b1;
         presc_q    <= '0;
      end else begin
         xtal_q     <= xtal_in;
         xtal_out_q <= ~xtal_in;
         if (wr_sec) begin
            presc_q <= '0; // R23
         end else if (xtal_rise) begin
            presc_q <= presc_q + 15'h0001; // R01
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         idle_q <= '0;
         osf_q  <= OSF_RST; // R11
      end else begin
         if (xtal_rise) begin
            idle_q <= '0;
         end else if (!osc_dead) begin
            idle_q <= idle_q + 16'h0001;
         end
         // a stop seen in the same cycle as a clearing write keeps the flag set
         if (osc_dead) begin
            osf_q <= 1'b1; // R11
         end else if (wr_sec && !wr_data[OSF_BIT]) begin
            osf_q <= 1'b0; // R23
         end
      end
   end

   // calendar carry chain
   assign sec_nx     = bcd_inc({1'b0, sec_q});
   assign min_nx     = bcd_inc({1'b0, min_q});
   assign hour_nx    = bcd_inc({2'b00, hour_q});
   assign date_nx    = bcd_inc({2'b00, date_q});
   assign month_nx   = bcd_inc({3'b000, month_q});
   assign year_nx    = bcd_inc(year_q);
   assign mlen       = month_len(month_q, year_q); // R06
   assign sec_wrap   = (sec_q == BCD_59);
   assign min_wrap   = (min_q == BCD_59);
   assign hour_wrap  = (hour_q == HOUR_LAST);
   assign day_roll   = tick && sec_wrap && min_wrap && hour_wrap; // R04
   assign date_wrap  = (date_q == mlen);
   assign month_wrap = (month_q == MONTH_LAST);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sec_q   <= '0;
         min_q   <= '0;
         hour_q  <= '0;
         date_q  <= DATE_RST;
         wday_q  <= '0;
         month_q <= MONTH_RST;
         year_q  <= '0;
      end else begin
         if (tick) begin
            sec_q <= sec_wrap ? 7'h00 : sec_nx[6:0]; // R03
         end
         if (tick && sec_wrap) begin
            min_q <= min_wrap ? 7'h00 : min_nx[6:0];
         end
         if (tick && sec_wrap && min_wrap) begin
            hour_q <= hour_wrap ? 6'h00 : hour_nx[5:0]; // R04
         end
         if (day_roll) begin
            date_q <= date_wrap ? DATE_RST : date_nx[5:0]; // R05
            wday_q <= (wday_q == WDAY_LAST) ? 3'h0 : wday_q + 3'h1; // R09
         end
         if (day_roll && date_wrap) begin
            month_q <= month_wrap ? MONTH_RST : month_nx[4:0]; // R07
         end
         if (day_roll && date_wrap && month_wrap) begin
            year_q <= (year_q == YEAR_LAST) ? 8'h00 : year_nx; // R08
         end
         // host writes win over the count; illegal codes are the host's problem
         if (wr_en) begin // R02 R10
            case (ptr_q)
               ADDR_SEC:   sec_q   <= wr_data[6:0]; // R24
               ADDR_MIN:   min_q   <= wr_data[6:0];
               ADDR_HOUR:  hour_q  <= wr_data[5:0];
               ADDR_DATE:  date_q  <= wr_data[5:0];
               ADDR_WDAY:  wday_q  <= wr_data[2:0];
               ADDR_MONTH: month_q <= wr_data[4:0];
               ADDR_YEAR:  year_q  <= wr_data;
               default: ;
            endcase
         end
      end
   end

   // alarm compare: a field with its off bit set always counts as matched
   assign alarm_match = (~&ae_q)
                        && (ae_q[0] || (al_min_q == min_q))
                        && (ae_q[1] || (al_hour_q == hour_q))
                        && (ae_q[2] || (al_date_q == date_q))
                        && (ae_q[3] || (al_wday_q == wday_q)); // R13
   assign alarm_hit   = alarm_match && !match_q; // R22

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ae_q      <= AE_RST;
         al_min_q  <= '0;
         al_hour_q <= '0;
         al_date_q <= '0;
         al_wday_q <= '0;
         aie_q     <= AIE_RST;
         square_out_enable_q    <= SQUARE_OUT_ENABLE_RST;
         rate_q    <= RATE_RST;
      end else if (wr_en) begin
         case (ptr_q)
            ADDR_CTRL_B: aie_q <= wr_data[AIE_BIT]; // R15
            ADDR_AL_MIN: begin
               ae_q[0]  <= wr_data[AE_BIT];
               al_min_q <= wr_data[6:0];
            end
            ADDR_AL_HOUR: begin
               ae_q[1]   <= wr_data[AE_BIT];
               al_hour_q <= wr_data[5:0];
            end
            ADDR_AL_DATE: begin
               ae_q[2]   <= wr_data[AE_BIT];
               al_date_q <= wr_data[5:0];
            end
            ADDR_AL_WDAY: begin
               ae_q[3]   <= wr_data[AE_BIT];
               al_wday_q <= wr_data[2:0];
            end
            ADDR_SQW: begin
               square_out_enable_q <= wr_data[SQUARE_OUT_ENABLE_BIT]; // R18
               rate_q <= wr_data[1:0]; // R19
            end
            default: ; // R20
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         match_q <= 1'b1;
         af_q    <= AF_RST;
      end else begin
         match_q <= alarm_match;
         // a fresh match in the clearing cycle keeps the flag set
         if (alarm_hit) begin
            af_q <= 1'b1; // R14 R22
         end else if (wr_en && (ptr_q == ADDR_CTRL_B) && !wr_data[AF_BIT]) begin
            af_q <= 1'b0; // R16
         end
      end
   end

   // the fastest rate is the crystal level itself, so it inherits the sampling jitter
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sq_wave_q <= 1'b1;
      end else begin
         case (rate_q)
            2'h0:    sq_wave_q <= xtal_q;
            2'h1:    sq_wave_q <= presc_q[TAP_1K];
            2'h2:    sq_wave_q <= presc_q[TAP_32];
            default: sq_wave_q <= presc_q[TAP_1]; // R19
         endcase
      end
   end

   assign xtal_out      = xtal_out_q;
   assign irq_n_level   = 1'b0;
   assign irq_n_oe      = af_q && aie_q; // R15 R17
   assign square_out    = 1'b0;
   assign square_out_oe = square_out_enable_q && !sq_wave_q; // R18

   // register read view
   always_comb begin
      rd_data = 8'h00; // R24
      case (ptr_q)
         ADDR_CTRL_B:  rd_data = {4'h0, af_q, 1'b0, aie_q, 1'b0}; // R16
         ADDR_SEC:     rd_data = {osf_q, sec_q}; // R11
         ADDR_MIN:     rd_data = {1'b0, min_q};
         ADDR_HOUR:    rd_data = {2'b00, hour_q};
         ADDR_DATE:    rd_data = {2'b00, date_q};
         ADDR_WDAY:    rd_data = {5'h00, wday_q};
         ADDR_MONTH:   rd_data = {3'h0, month_q};
         ADDR_YEAR:    rd_data = year_q; // R02
         ADDR_AL_MIN:  rd_data = {ae_q[0], al_min_q};
         ADDR_AL_HOUR: rd_data = {ae_q[1], 1'b0, al_hour_q};
         ADDR_AL_DATE: rd_data = {ae_q[2], 1'b0, al_date_q};
         ADDR_AL_WDAY: rd_data = {ae_q[3], 4'h0, al_wday_q};
         ADDR_SQW:     rd_data = {square_out_enable_q, 5'h00, rate_q};
         default:      rd_data = 8'h00; // R20
      endcase
   end

   // two-wire target; sampling at 100 mhz gives ample margin at 400 khz scl
   assign scl_rise  = scl && !scl_q;
   assign scl_fall  = !scl && scl_q;
   assign bus_start = scl && scl_q && sda_q && !sda_pin;
   assign bus_stop  = scl && scl_q && !sda_q && sda_pin;
   assign wr_en     = (state_q == ST_RX) && scl_fall && (cnt_q == 4'h8) && !first_q; // R21
   assign wr_data   = shreg_q;
   assign ptr_next  = (ptr_q == ADDR_SQW) ? ADDR_CTRL_A : ptr_q + 8'h01;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         scl_q    <= 1'b1;
         sda_q    <= 1'b1;
         state_q  <= ST_IDLE;
         cnt_q    <= '0;
         shreg_q  <= '0;
         tx_q     <= '0;
         ptr_q    <= '0;
         rw_q     <= 1'b0;
         first_q  <= 1'b0;
         nack_q   <= 1'b1;
         sda_oe_q <= 1'b0;
      end else begin
         scl_q <= scl;
         sda_q <= sda_pin;
         if (bus_start) begin
            state_q  <= ST_ADDR;
            cnt_q    <= '0;
            sda_oe_q <= 1'b0;
         end else if (bus_stop) begin
            state_q  <= ST_IDLE;
            sda_oe_q <= 1'b0;
         end else if (scl_rise) begin
            case (state_q)
               ST_ADDR, ST_RX: begin
                  shreg_q <= {shreg_q[6:0], sda_pin};
                  cnt_q   <= cnt_q + 4'h1;
               end
               ST_TX:     cnt_q  <= cnt_q + 4'h1;
               ST_TX_ACK: nack_q <= sda_pin;
               default: ;
            endcase
         end else if (scl_fall) begin
            case (state_q)
               ST_ADDR: begin
                  if (cnt_q == 4'h8) begin
                     if (shreg_q[7:1] == TARGET_ADDR) begin
                        state_q  <= ST_ADDR_ACK; // R21
                        sda_oe_q <= 1'b1;
                        rw_q     <= shreg_q[0];
                     end else begin
                        state_q <= ST_IDLE;
                     end
                  end
               end
               ST_ADDR_ACK: begin
                  cnt_q <= '0;
                  if (rw_q) begin
                     state_q  <= ST_TX;
                     tx_q     <= rd_data;
                     sda_oe_q <= !rd_data[7];
                  end else begin
                     state_q  <= ST_RX;
                     first_q  <= 1'b1;
                     sda_oe_q <= 1'b0;
                  end
               end
               ST_RX: begin
                  if (cnt_q == 4'h8) begin
                     state_q  <= ST_RX_ACK;
                     sda_oe_q <= 1'b1;
                     first_q  <= 1'b0;
                     ptr_q    <= first_q ? shreg_q : ptr_next;
                  end
               end
               ST_RX_ACK: begin
                  state_q  <= ST_RX;
                  cnt_q    <= '0;
                  sda_oe_q <= 1'b0;
               end
               ST_TX: begin
                  if (cnt_q == 4'h8) begin
                     state_q  <= ST_TX_ACK;
                     sda_oe_q <= 1'b0;
                     ptr_q    <= ptr_next;
                  end else begin
                     sda_oe_q <= !tx_q[~cnt_q[2:0]];
                  end
               end
               ST_TX_ACK: begin
                  cnt_q <= '0;
                  if (nack_q) begin
                     state_q <= ST_IDLE;
                  end else begin
                     state_q  <= ST_TX;
                     tx_q     <= rd_data;
                     sda_oe_q <= !rd_data[7];
                  end
               end
               default: state_q <= ST_IDLE;
            endcase
         end
      end
   end

   assign sda_level = 1'b0;
   assign sda_oe    = sda_oe_q;

   sequence s_day_roll;
      day_roll && !wr_en;
   endsequence

   sequence s_fresh_match;
      !alarm_match ##1 alarm_match;
   endsequence

   sequence s_addr_hit;
      (state_q == ST_ADDR) && scl_fall && !bus_start && !bus_stop && (cnt_q == 4'h8)
      && (shreg_q[7:1] == TARGET_ADDR);
   endsequence

   chk_sec_advance: assert property (@(posedge clk) disable iff (sys_rst) // R01
      tick && !sec_wrap && !wr_en |=> sec_q == $past(sec_nx[6:0]))
      else $error("seconds did not advance on tick");

   chk_hour_wrap: assert property (@(posedge clk) disable iff (sys_rst) // R04
      s_day_roll |=> (hour_q == 6'h00) && (min_q == 7'h00) && (sec_q == 7'h00))
      else $error("hour did not wrap to 00");

   chk_feb_plain: assert property (@(posedge clk) disable iff (sys_rst) // R05
      s_day_roll and (month_q == MONTH_FEB && date_q == 6'h28
                      && (year_q[0] || (year_q[1] != year_q[4])))
      |=> date_q == DATE_RST && month_q == 5'h03)
      else $error("february end wrong in common year");

   chk_leap_day: assert property (@(posedge clk) disable iff (sys_rst) // R06
      s_day_roll and (month_q == MONTH_FEB && date_q == 6'h28
                      && !year_q[0] && (year_q[1] == year_q[4]))
      |=> date_q == 6'h29 && month_q == MONTH_FEB)
      else $error("leap day skipped");

   chk_year_carry: assert property (@(posedge clk) disable iff (sys_rst) // R07
      s_day_roll and (month_q == MONTH_LAST && date_q == 6'h31 && year_q == 8'h41)
      |=> month_q == MONTH_RST && year_q == 8'h42)
      else $error("month did not carry into year");

   chk_year_wrap: assert property (@(posedge clk) disable iff (sys_rst) // R08
      s_day_roll and (month_q == MONTH_LAST && date_q == 6'h31 && year_q == YEAR_LAST)
      |=> year_q == 8'h00)
      else $error("year did not wrap to 00");

   chk_wday_wrap: assert property (@(posedge clk) disable iff (sys_rst) // R09
      s_day_roll and (wday_q == WDAY_LAST) |=> wday_q == 3'h0)
      else $error("weekday did not wrap");

   chk_osf_set: assert property (@(posedge clk) disable iff (sys_rst) // R11
      osc_dead && !xtal_rise |=> osf_q ##1 osf_q)
      else $error("oscillator fail not flagged");

   chk_alarm_fresh: assert property (@(posedge clk) disable iff (sys_rst) // R22
      s_fresh_match |=> af_q)
      else $error("alarm flag missed a fresh match");

   chk_af_clear: assert property (@(posedge clk) disable iff (sys_rst) // R16
      wr_en && ptr_q == ADDR_CTRL_B && !wr_data[AF_BIT] && !alarm_hit |=> !af_q && !irq_n_oe)
      else $error("alarm flag not cleared by write of 0");

   chk_af_keep: assert property (@(posedge clk) disable iff (sys_rst) // R16
      af_q && wr_en && ptr_q == ADDR_CTRL_B && wr_data[AF_BIT] |=> af_q)
      else $error("alarm flag lost on write of 1");

   chk_addr_ack: assert property (@(posedge clk) disable iff (sys_rst) // R21
      s_addr_hit |=> sda_oe && state_q == ST_ADDR_ACK)
      else $error("own address not acknowledged");

   chk_sqw_off: assert property (@(posedge clk) disable iff (sys_rst) // R18
      wr_en && ptr_q == ADDR_SQW && !wr_data[SQUARE_OUT_ENABLE_BIT] |=> !square_out_oe [*2])
      else $error("square output driven while disabled");

endmodule : brs_rtc

`default_nettype wire

// ===== bench/brs_host_model.sv
// Purpose: two-wire bus host model facing the rtc target
// Assumes: open-drain data wire with pull-up; scl only moves inside frames
// Notes:   the testbench calls the tasks; the host releases the wire when idle
`timescale 1ns/1ns
`default_nettype none
module brs_host_model (
   input  wire logic clk,
   input  wire logic sda_oe,
   output logic      scl,
   output wire logic sda
);
   logic pull_low;
   // wired-and of both parties, pull-up when nobody pulls
   assign sda = !(pull_low | sda_oe);
   initial begin
      scl = 1'b1;
      pull_low = 1'b0;
   end
   // 4 x 63 clks keeps scl at or below 400 khz
   task automatic quarter;
      repeat (63) @(negedge clk);
   endtask : quarter
   task automatic start;
      pull_low = 1'b0;
      quarter();
      scl = 1'b1;
      quarter();
      pull_low = 1'b1;
      quarter();
      scl = 1'b0;
   endtask : start
   task automatic stop;
      pull_low = 1'b1;
      quarter();
      scl = 1'b1;
      quarter();
      pull_low = 1'b0;
      quarter();
   endtask : stop
   // eight bits msb first then the ack bit; r holds what the wire showed
   task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [8:0] r);
      logic [8:0] w;
      w = {d, ack_in};
      for (int i = 8; i >= 0; i--) begin
         pull_low = !w[i];
         quarter();
         scl = 1'b1;
         quarter();
         r[i] = sda;
         quarter();
         scl = 1'b0;
         quarter();
      end
   endtask : xfer
endmodule : brs_host_model
`default_nettype wire

// ===== bench/test_brs_rtc.sv
// Purpose: self-checking bench for the bcd rtc with alarm
// Assumes: crystal stand-in toggles every clk so one second is 65536 clks
// Notes:   one burst sets time and alarm, one tick is awaited, one burst reads back
`timescale 1ns/1ns
`default_nettype none
module test_brs_rtc;
   import brs_pkg::*;
   logic       clk, sys_rst, xtal_in, scl, sda, sda_level, sda_oe, xtal_out;
   logic       irq_n_level, irq_n_oe, square_out, square_out_oe, nack, xtal_run;
   logic [8:0] r;
   logic [7:0] yr;
   int         wd, mismatches, samples_checked;
   brs_rtc #(.OSC_TIMEOUT_CYCLES(64)) i_brs_rtc (.clk(clk), .sys_rst(sys_rst), .scl(scl),
      .sda_pin(sda), .sda_level(sda_level), .sda_oe(sda_oe), .xtal_in(xtal_in),
      .xtal_out(xtal_out), .irq_n_level(irq_n_level), .irq_n_oe(irq_n_oe),
      .square_out(square_out), .square_out_oe(square_out_oe));
   brs_host_model host (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(negedge clk) if (xtal_run) xtal_in <= ~xtal_in;
   function automatic logic [7:0] bcd(input int v);
      return 8'((v / 10) * 16 + v % 10);
   endfunction : bcd
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic send(input logic [7:0] d);
      host.xfer(d, 1'b1, r);
      nack = nack | r[0];
   endtask : send
   task automatic complete_run;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : complete_run
   initial begin
      logic [7:0] wr_data [14];
      logic [7:0] exp [9];
      sys_rst = 1'b1;
      xtal_in = 1'b0;
      xtal_run = 1'b1;
      nack = 1'b0;
      mismatches = 0;
      samples_checked = 0;
      void'($urandom(32'he7f0));
      // leap years only, so february 28 must step to 29
      yr = bcd(4 * ($urandom % 25));
      wd = $urandom % 7;
      repeat (6) @(negedge clk);
      sys_rst = 1'b0;
      @(negedge clk);
      check("irq_n_oe reset", 8'h00, {7'h0, irq_n_oe});
      // minute alarm at 00 only, square wave off, irq enabled via wrap 0d->00->01
      wr_data = '{8'h59, 8'h59, 8'h23, 8'h28, 8'(wd), 8'h02, yr,
                  8'h00, 8'h80, 8'h80, 8'h80, 8'h00, 8'h00, 8'h02};
      host.start();
      send({TARGET_ADDR, 1'b0});
      send(ADDR_SEC);
      foreach (wr_data[i]) send(wr_data[i]);
      host.stop();
      $display("test write burst done");
      for (int i = 0; i < 70000 && irq_n_oe !== 1'b1; i++) @(negedge clk);
      check("irq_n_oe alarm", 8'h01, {7'h0, irq_n_oe});
      check("square_out_oe", 8'h00, {7'h0, square_out_oe});
      if (mismatches != 0) complete_run();
      // park the crystal past the stop window so the fail flag must come back
      xtal_run <= 1'b0;
      repeat (80) @(negedge clk);
      check("xtal_out", {7'h0, ~xtal_in}, {7'h0, xtal_out});
      check("open drain levels", 8'h00, {5'h0, sda_level, irq_n_level, square_out});
      xtal_run <= 1'b1;
      exp = '{8'h00, 8'h0a, 8'h80, 8'h00, 8'h00, 8'h29, 8'((wd + 1) % 7), 8'h02, yr};
      host.start();
      send({TARGET_ADDR, 1'b0});
      send(ADDR_CTRL_A);
      host.start();
      send({TARGET_ADDR, 1'b1});
      for (int i = 0; i < 9; i++) begin
         host.xfer(8'hff, i == 8, r);
         check($sformatf("reg %0d", i), exp[i], r[8:1]);
      end
      host.stop();
      $display("test read burst done");
      host.start();
      send({TARGET_ADDR, 1'b0});
      send(ADDR_CTRL_B);
      send(8'h02);
      host.stop();
      repeat (4) @(negedge clk);
      check("irq_n_oe cleared", 8'h00, {7'h0, irq_n_oe});
      check("ack", 8'h00, {7'h0, nack});
      $display("test alarm clear done");
      complete_run();
   end
endmodule : test_brs_rtc
`default_nettype wire
